// ===== inc/tss_consts.vh
// constants for the 256 x 256 time slot switch
// assumes a single 250 MHz clock; included by bare name
// Function
// [RULE1] any of 256 inputs reaches any of 256 outputs, 8 lines of 32
// [RULE2] serial lines run at 2.048 Mb/s, 125 us frames of 32 bytes
// [RULE3] a continuous 4.096 MHz serial clock shifts every input and output bit
// [RULE4] frame pulse format and polarity are found automatically, framing follows
// [RULE5] each output channel selects variable or constant throughput delay
// [RULE6] single channels and grouped multi-channel data are both switched
// [RULE7] processor mode lets the host source outputs and read received bytes
// [RULE8] host port has an 8-bit two-way data bus and six address inputs
// [RULE9] host access happens only while the active-low chip select is low
// [RULE10] active-high data strobe with chip select starts the access
// [RULE11] read/write input sets bus direction: device drives on reads
// [RULE12] open-drain active-low acknowledge pulls low when the transfer is done
// [RULE13] host reaches control register, high and low connection memory, data memory
// [RULE14] master output enable low floats all eight serial outputs
// [RULE15] master output enable high lets each channel enable bit decide
// [RULE16] control channel output sends 256 bits per frame from per-channel bits
// [RULE17] connection mode: low connection memory names the source; broadcast allowed
// [RULE18] processor mode: host byte is sent every frame until rewritten
// [RULE19] constant delay: input of frame N leaves in frame N+2
// [RULE20] frame pulse is active high in one format, active low in the other
// [RULE21] control channel bits go in line order, then channel order, from frame start
// [RULE22] outputs stay floating after reset until the host programs the channels
`ifndef TSS_CONSTS_VH
`define TSS_CONSTS_VH
`define TSS_ADR_MEM        5
`define TSS_CTL_LINE_HI    2
`define TSS_CTL_MSEL_LO    3
`define TSS_CTL_MSEL_HI    4
`define TSS_STS_LOCK       6
`define TSS_STS_FMT        7
`define TSS_MSEL_DM        2'h0
`define TSS_MSEL_CML       2'h1
`define TSS_MSEL_CMH       2'h2
`define TSS_CMH_OE         0
`define TSS_CMH_CC         1
`define TSS_CMH_CONST      2
`define TSS_CMH_PROC       3
`define TSS_IDLE_EDGES     8'h10
`define TSS_VAR_MIN_SLOTS  5'h03
`define TSS_CONST_FRAMES   2'h2
`endif

// ===== logic/tss_sync.v
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins; one clock domain
`timescale 1ns/1ps
module tss_sync #(
   parameter W = 1
) (
   // clock and reset
   input  wire         clock,
   input  wire         rst,
   // pins and filtered levels
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;

   // a bit moves only when stages two and three agree
   always @(posedge clock) begin
      if (rst) begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
         s3_r <= {W{1'b0}};
         dout <= {W{1'b0}};
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         dout <= (s2_r & s3_r) | (dout & (s2_r ^ s3_r));
      end
   end
endmodule // tss_sync

// ===== logic/tss_ram.v
// simple memory: one write port, two registered read ports
// assumes no reset of contents; read data one cycle after address
`timescale 1ns/1ps
module tss_ram #(
   parameter AW = 8,
   parameter DW = 8
) (
   // clock
   input  wire          clock,
   // write port
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   // read ports
   input  wire [AW-1:0] raddr_a,
   output reg  [DW-1:0] rdata_a,
   input  wire [AW-1:0] raddr_b,
   output reg  [DW-1:0] rdata_b
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // write and both reads
   always @(posedge clock) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
   end
endmodule // tss_ram

// ===== logic/tss_switch.v
// time slot interchange switch: 8 serial lines in, 8 out, host port
// assumes serial clock, frame pulse and host pins are asynchronous
`timescale 1ns/1ps
`include "tss_consts.vh"
module tss_switch (
   // clock and reset
   input  wire        clock,
   input  wire        rst,
   // serial backplane
   input  wire [7:0]  serial_in_lines,
   input  wire        frame_pulse_in,
   input  wire        serial_clock_in,
   input  wire        master_output_enable,
   output reg  [7:0]  serial_out_lines,
   output reg  [7:0]  serial_out_en,
   output reg         control_channel_out,
   // host port
   input  wire        chip_select_n,
   input  wire        data_strobe,
   input  wire        read_not_write,
   input  wire [5:0]  addr_lines,
   input  wire [7:0]  host_data_bus_pin,
   output reg  [7:0]  host_data_bus_drv,
   output reg         host_data_bus_en,
   output reg         transfer_ack_n_drv,
   output reg         transfer_ack_n_en
);
   localparam F_IDLE = 2'h0;
   localparam F_CM   = 2'h1;
   localparam F_DM   = 2'h2;
   localparam F_ST   = 2'h3;
   localparam H_IDLE = 2'h0;
   localparam H_RD   = 2'h1;
   localparam H_ACK  = 2'h2;

   // subtract k frames from a bank index modulo three
   function [1:0] bank_sub;
      input [1:0] b;
      input [1:0] k;
      reg   [2:0] t;
      begin
         t = {1'b0, b} + 3'h3 - {1'b0, k};
         if (t >= 3'h3) begin
            t = t - 3'h3;
         end
         bank_sub = t[1:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // pin synchronisers
   wire [27:0] syn;
   wire [7:0]  sin_s  = syn[27:20];
   wire        fp_s   = syn[19];
   wire        sck_s  = syn[18];
   wire        moe_s  = syn[17];
   wire        csn_s  = syn[16];
   wire        ds_s   = syn[15];
   wire        rnw_s  = syn[14];
   wire [5:0]  adr_s  = syn[13:8];
   wire [7:0]  din_s  = syn[7:0];

   tss_sync #(.W(28)) u_sync (
      .clock (clock),
      .rst   (rst),
      .din   ({serial_in_lines, frame_pulse_in, serial_clock_in, master_output_enable,
               chip_select_n, data_strobe, read_not_write, addr_lines, host_data_bus_pin}),
      .dout  (syn)
   );

   ////////////////////////////////////////////////////////////////
   // serial clock edges and frame format detection
   reg        sck_d_r;
   reg        fp_last_r;
   reg [7:0]  run_r;
   reg        idle_lvl_r;
   reg        fmt_gci_r;
   reg        locked_r;
   reg        fp_act_d_r;
   wire       sck_rise = sck_s & ~sck_d_r;
   wire       sck_fall = ~sck_s & sck_d_r;
   wire       fp_act   = fp_s ^ idle_lvl_r;                  // see [RULE20]
   wire       bnd_edge = fmt_gci_r ? sck_rise : sck_fall;
   wire       smp_edge = fmt_gci_r ? sck_fall : sck_rise;
   wire       frame_go = bnd_edge & fp_act_d_r & ~fp_act & locked_r;

   // the long-held level is idle; the pulse is its opposite
   always @(posedge clock) begin
      if (rst) begin
         sck_d_r    <= 1'b0;
         fp_last_r  <= 1'b0;
         run_r      <= 8'h00;
         idle_lvl_r <= 1'b1;
         fmt_gci_r  <= 1'b0;
         locked_r   <= 1'b0;
         fp_act_d_r <= 1'b0;
      end else begin
         sck_d_r <= sck_s;                                    // see [RULE3]
         if (sck_fall) begin
            fp_last_r <= fp_s;
            if (fp_s != fp_last_r) begin
               run_r <= 8'h00;
            end else if (run_r != `TSS_IDLE_EDGES) begin
               run_r <= run_r + 8'h01;
            end else begin
               idle_lvl_r <= fp_s;                            // see [RULE4]
               fmt_gci_r  <= ~fp_s;                           // see [RULE20]
               locked_r   <= 1'b1;
            end
         end
         if (bnd_edge) begin
            fp_act_d_r <= fp_act;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // bit timing: two serial clocks per bit, 256 bits per frame
   reg        phase_r;
   reg [7:0]  bitcnt_r;
   reg        bnd_d_r;
   reg [1:0]  cur_bank_r;
   wire       bit_bnd  = bnd_edge & (phase_r | frame_go);
   wire       sample   = smp_edge & phase_r;                 // three quarters into the bit
   wire       ch_start = bnd_d_r & (bitcnt_r[2:0] == 3'h0);

   always @(posedge clock) begin
      if (rst) begin
         phase_r    <= 1'b0;
         bitcnt_r   <= 8'h00;
         bnd_d_r    <= 1'b0;
         cur_bank_r <= 2'h0;
      end else begin
         bnd_d_r <= bit_bnd;
         if (frame_go) begin
            phase_r    <= 1'b0;
            bitcnt_r   <= 8'h00;                              // see [RULE2]
            cur_bank_r <= bank_sub(cur_bank_r, 2'h2);         // see [RULE19]
         end else if (bnd_edge) begin
            phase_r <= ~phase_r;
            if (phase_r) begin
               bitcnt_r <= bitcnt_r + 8'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // receive: shift in, capture all lines, write them one by one
   reg [63:0] rx_sh_r;
   reg [63:0] rx_cap_r;
   reg [4:0]  rx_chan_r;
   reg [1:0]  rx_bank_r;
   reg        wr_busy_r;
   reg [2:0]  wr_line_r;
   wire       cap = sample & (bitcnt_r[2:0] == 3'h7);
   integer    int_i;

   genvar gl;
   generate
      for (gl = 0; gl < 8; gl = gl + 1) begin : g_rx
         // msb first
         always @(posedge clock) begin
            if (rst) begin
               rx_sh_r[gl*8 +: 8] <= 8'h00;
            end else if (sample) begin
               rx_sh_r[gl*8 +: 8] <= {rx_sh_r[gl*8 +: 7], sin_s[gl]};
            end
         end
      end
   endgenerate

   // eight writes take eight cycles, far inside one bit time
   always @(posedge clock) begin
      if (rst) begin
         rx_cap_r  <= 64'h0;
         rx_chan_r <= 5'h00;
         rx_bank_r <= 2'h0;
         wr_busy_r <= 1'b0;
         wr_line_r <= 3'h0;
      end else if (cap) begin
         for (int_i = 0; int_i < 8; int_i = int_i + 1) begin
            rx_cap_r[int_i*8 +: 8] <= {rx_sh_r[int_i*8 +: 7], sin_s[int_i]};
         end
         rx_chan_r <= bitcnt_r[7:3];
         rx_bank_r <= cur_bank_r;
         wr_busy_r <= 1'b1;
         wr_line_r <= 3'h0;
      end else if (wr_busy_r) begin
         wr_line_r <= wr_line_r + 3'h1;
         wr_busy_r <= (wr_line_r != 3'h7);
      end
   end

   ////////////////////////////////////////////////////////////////
   // host port state and memory write strobes
   reg [1:0]  hst_r;
   reg [4:0]  ctrl_r;
   reg        armed_r;
   reg [255:0] cc_bits_r;
   wire       req   = ~csn_s & ds_s;                          // see [RULE9] [RULE10]
   wire       hwr   = (hst_r == H_IDLE) & req & ~rnw_s;      // see [RULE11]
   wire       hmem  = adr_s[`TSS_ADR_MEM];                    // see [RULE8]
   wire [1:0] msel  = ctrl_r[`TSS_CTL_MSEL_HI:`TSS_CTL_MSEL_LO];
   wire [7:0] hidx  = {ctrl_r[`TSS_CTL_LINE_HI:0], adr_s[4:0]};
   wire       cml_we = hwr & hmem & (msel == `TSS_MSEL_CML);
   wire       cmh_we = hwr & hmem & (msel == `TSS_MSEL_CMH);

   ////////////////////////////////////////////////////////////////
   // memories: data (three frame banks), low and high connection
   reg [1:0]  fst_r;
   reg [2:0]  fline_r;
   reg [4:0]  fch_r;
   wire [7:0] cml_qa;
   wire [7:0] cml_qb;
   wire [3:0] cmh_qa;
   wire [3:0] cmh_qb;
   wire [7:0] dm_qa;
   wire [7:0] dm_qb;
   wire [4:0] d5     = fch_r - cml_qa[4:0];
   wire [1:0] k_var  = {1'b0, (fch_r < cml_qa[4:0])} + {1'b0, (d5 < `TSS_VAR_MIN_SLOTS)};
   wire [1:0] k_sel  = cmh_qa[`TSS_CMH_CONST] ? `TSS_CONST_FRAMES : k_var; // see [RULE5]
   wire [1:0] out_bk = (fch_r == 5'h00) ? bank_sub(cur_bank_r, 2'h2) : cur_bank_r;
   wire [1:0] src_bk = bank_sub(out_bk, k_sel);               // see [RULE19]
   wire [1:0] host_bk = bank_sub(cur_bank_r, 2'h1);

   tss_ram #(.AW(10), .DW(8)) u_dm (
      .clock   (clock),
      .we      (wr_busy_r),
      .waddr   ({rx_bank_r, wr_line_r, rx_chan_r}),
      .wdata   (rx_cap_r[wr_line_r*8 +: 8]),
      .raddr_a ({src_bk, cml_qa}),                            // see [RULE1] [RULE17]
      .rdata_a (dm_qa),
      .raddr_b ({host_bk, hidx}),                             // see [RULE7]
      .rdata_b (dm_qb)
   );

   tss_ram #(.AW(8), .DW(8)) u_cml (
      .clock   (clock),
      .we      (cml_we),
      .waddr   (hidx),
      .wdata   (din_s),
      .raddr_a ({fline_r, fch_r}),
      .rdata_a (cml_qa),
      .raddr_b (hidx),
      .rdata_b (cml_qb)
   );

   tss_ram #(.AW(8), .DW(4)) u_cmh (
      .clock   (clock),
      .we      (cmh_we),
      .waddr   (hidx),
      .wdata   (din_s[3:0]),
      .raddr_a ({fline_r, fch_r}),
      .rdata_a (cmh_qa),
      .raddr_b (hidx),
      .rdata_b (cmh_qb)
   );

   ////////////////////////////////////////////////////////////////
   // fetch next channel of every line during the current slot
   reg [63:0] stage_r;
   reg [7:0]  stage_oe_r;
   reg [7:0]  cml_h_r;
   reg        proc_h_r;
   reg        oe_h_r;

   always @(posedge clock) begin
      if (rst) begin
         fst_r      <= F_IDLE;
         fline_r    <= 3'h0;
         fch_r      <= 5'h00;
         stage_r    <= 64'h0;
         stage_oe_r <= 8'h00;
         cml_h_r    <= 8'h00;
         proc_h_r   <= 1'b0;
         oe_h_r     <= 1'b0;
      end else begin
         case (fst_r)
            F_IDLE: begin
               if (ch_start) begin
                  fline_r <= 3'h0;
                  fch_r   <= bitcnt_r[7:3] + 5'h01;
                  fst_r   <= F_CM;
               end
            end
            F_CM: begin
               fst_r <= F_DM;
            end
            F_DM: begin
               cml_h_r  <= cml_qa;
               proc_h_r <= cmh_qa[`TSS_CMH_PROC];
               oe_h_r   <= cmh_qa[`TSS_CMH_OE];
               fst_r    <= F_ST;
            end
            F_ST: begin
               // processor mode repeats the host byte every frame
               stage_r[fline_r*8 +: 8] <= proc_h_r ? cml_h_r : dm_qa; // see [RULE18] [RULE6]
               stage_oe_r[fline_r]     <= oe_h_r;
               fline_r <= fline_r + 3'h1;
               fst_r   <= (fline_r == 3'h7) ? F_IDLE : F_CM;
            end
            default: begin
               fst_r <= F_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // transmit shifters and three-state enables
   reg [63:0] tx_sh_r;
   reg [7:0]  cur_oe_r;

   generate
      for (gl = 0; gl < 8; gl = gl + 1) begin : g_tx
         // enable follows the master pin every cycle, not only at slots
         always @(posedge clock) begin
            if (rst) begin
               tx_sh_r[gl*8 +: 8]  <= 8'h00;
               cur_oe_r[gl]        <= 1'b0;
               serial_out_lines[gl] <= 1'b0;
               serial_out_en[gl]   <= 1'b0;
            end else begin
               if (ch_start) begin
                  tx_sh_r[gl*8 +: 8]   <= {stage_r[gl*8 +: 7], 1'b0};
                  serial_out_lines[gl] <= stage_r[gl*8 + 7];
                  cur_oe_r[gl]         <= stage_oe_r[gl];
               end else if (bnd_d_r) begin
                  tx_sh_r[gl*8 +: 8]   <= {tx_sh_r[gl*8 +: 7], 1'b0};
                  serial_out_lines[gl] <= tx_sh_r[gl*8 + 7];
               end
               serial_out_en[gl] <= moe_s & armed_r & cur_oe_r[gl]; // see [RULE14] [RULE15] [RULE22]
            end
         end
      end
   endgenerate

   // control channel: one stored bit per bit time, index = line, channel
   always @(posedge clock) begin
      if (rst) begin
         control_channel_out <= 1'b0;
      end else if (bnd_d_r) begin
         control_channel_out <= cc_bits_r[bitcnt_r];          // see [RULE16] [RULE21]
      end
   end

   ////////////////////////////////////////////////////////////////
   // host access sequencer
   reg [7:0] rd_mux;

   // read source by address space and memory select
   always @* begin
      rd_mux = 8'h00;
      if (!hmem) begin
         rd_mux = {fmt_gci_r, locked_r, 1'b0, ctrl_r};
      end else begin
         case (msel)
            `TSS_MSEL_DM:  rd_mux = dm_qb;
            `TSS_MSEL_CML: rd_mux = cml_qb;
            `TSS_MSEL_CMH: rd_mux = {4'h0, cmh_qb};
            default:       rd_mux = 8'h00;
         endcase
      end
   end

   // ack holds until the strobe or select drops
   always @(posedge clock) begin
      if (rst) begin
         hst_r              <= H_IDLE;
         ctrl_r             <= 5'h00;
         armed_r            <= 1'b0;
         cc_bits_r          <= 256'h0;
         host_data_bus_drv  <= 8'h00;
         host_data_bus_en   <= 1'b0;
         transfer_ack_n_drv <= 1'b0;
         transfer_ack_n_en  <= 1'b0;
      end else begin
         transfer_ack_n_drv <= 1'b0;
         case (hst_r)
            H_IDLE: begin
               if (req) begin
                  if (rnw_s) begin
                     hst_r <= H_RD;
                  end else begin
                     if (!hmem) begin
                        ctrl_r <= din_s[4:0];                 // see [RULE13]
                     end
                     if (cmh_we) begin
                        cc_bits_r[hidx] <= din_s[`TSS_CMH_CC];
                        armed_r         <= 1'b1;
                     end
                     transfer_ack_n_en <= 1'b1;               // see [RULE12]
                     hst_r             <= H_ACK;
                  end
               end
            end
            H_RD: begin
               host_data_bus_drv <= rd_mux;
               host_data_bus_en  <= 1'b1;                     // see [RULE11]
               transfer_ack_n_en <= 1'b1;                     // see [RULE12]
               hst_r             <= H_ACK;
            end
            H_ACK: begin
               if (!req) begin
                  host_data_bus_en  <= 1'b0;
                  transfer_ack_n_en <= 1'b0;
                  hst_r             <= H_IDLE;
               end
            end
            default: begin
               hst_r <= H_IDLE;
            end
         endcase
      end
   end
endmodule // tss_switch

// ===== testbench/tss_switch_props.sv
// time slot switch port checker
// assumes one clock, sync high reset
`timescale 1ns/1ps
module tss_switch_props (
   // clock and reset
   input wire       clock,
   input wire       rst,
   // serial side
   input wire       serial_clock_in,
   input wire       master_output_enable,
   input wire [7:0] serial_out_lines,
   input wire [7:0] serial_out_en,
   input wire       control_channel_out,
   // host side
   input wire       chip_select_n,
   input wire       data_strobe,
   input wire       read_not_write,
   input wire [5:0] addr_lines,
   input wire       host_data_bus_en,
   input wire       transfer_ack_n_drv,
   input wire       transfer_ack_n_en
);
   reg       sclk_r;
   reg [5:0] since_edge_r;
   reg       armed_r;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   // cycles since serial clock edge; saturates
   always @(posedge clock) begin
      sclk_r <= serial_clock_in;
      if (rst || sclk_r != serial_clock_in) since_edge_r <= 6'h00;
      else if (since_edge_r != 6'h3f) since_edge_r <= since_edge_r + 6'h01;
   end
   // raw write arms first; filtered design lags
   always @(posedge clock) begin
      if (rst) armed_r <= 1'b0;
      else if (!chip_select_n && data_strobe && !read_not_write && addr_lines[5]) armed_r <= 1'b1;
   end
   ////////////////////////////////////////
   // host handshake steps
   sequence s_req_start;
      $rose(data_strobe) && !chip_select_n;
   endsequence
   sequence s_released;
      transfer_ack_n_en && chip_select_n;
   endsequence
   a_ack_timely: assert property (s_req_start |-> ##[2:12] transfer_ack_n_en)
      else $error("no ack");
   a_ack_needs_select: assert property ($rose(transfer_ack_n_en) |->
      $past(chip_select_n, 2) == 1'b0 && $past(data_strobe, 2)) else $error("ack unasked");
   a_ack_release: assert property (s_released |-> ##[1:8] !transfer_ack_n_en)
      else $error("ack held");
   a_ack_pull_low: assert property (transfer_ack_n_en |-> !transfer_ack_n_drv)
      else $error("ack high");
   a_bus_on_read: assert property (host_data_bus_en |-> transfer_ack_n_en && read_not_write)
      else $error("bus not read");
   a_no_ack_unsel: assert property (chip_select_n [*8] |=> !transfer_ack_n_en)
      else $error("ack unselected");
   a_master_float: assert property (!master_output_enable [*8] |-> serial_out_en == 8'h00)
      else $error("master float");
   a_arm_float: assert property (!armed_r |-> serial_out_en == 8'h00)
      else $error("early drive");
   a_out_near_edge: assert property ($changed(serial_out_lines) || $changed(control_channel_out) |->
      since_edge_r <= 6'h0c) else $error("mid-bit change");
endmodule // tss_switch_props
bind tss_switch tss_switch_props u_props (.clock(clock), .rst(rst), .serial_clock_in(serial_clock_in),
   .master_output_enable(master_output_enable), .serial_out_lines(serial_out_lines),
   .serial_out_en(serial_out_en), .control_channel_out(control_channel_out), .chip_select_n(chip_select_n),
   .data_strobe(data_strobe), .read_not_write(read_not_write), .addr_lines(addr_lines),
   .host_data_bus_en(host_data_bus_en), .transfer_ack_n_drv(transfer_ack_n_drv),
   .transfer_ack_n_en(transfer_ack_n_en));

// ===== testbench/tss_line_partner.sv
// far side: serial clock, low frame pulse, eight lines
// bench reads the frame position
`timescale 1ns/1ps
module tss_line_partner (
   // serial backplane
   output reg       serial_clock_in,
   output reg       frame_pulse_in,
   output reg [7:0] serial_in_lines,
   // frame position
   output reg [8:0] slot_pos,
   output reg [3:0] frame_no
);
   reg [7:0] byte_v;
   integer   l;
   // same byte every frame, so any delay fits
   function [7:0] in_byte(input [7:0] src);
      in_byte = {src[4:0], src[7:5]} ^ 8'h5a;
   endfunction
   ////////////////////////////////////////
   // free clock; late start shortens the run
   initial begin
      serial_clock_in = 1'b1;
      frame_pulse_in = 1'b1;
      serial_in_lines = 8'h00;
      slot_pos = 9'h1e0;
      frame_no = 4'h0;
      forever #122.07 serial_clock_in = ~serial_clock_in;
   end
   // boundary every second fall, msb first
   always @(negedge serial_clock_in) begin
      slot_pos = slot_pos + 9'h001;
      if (slot_pos == 9'h000) frame_no = frame_no + 4'h1;
      if (!slot_pos[0]) begin
         for (l = 0; l < 8; l = l + 1) begin
            byte_v = in_byte({l[2:0], slot_pos[8:4]});
            serial_in_lines[l] = byte_v[7 - slot_pos[3:1]];
         end
      end
   end
   // low pulse spans the last boundary
   always @(posedge serial_clock_in) begin
      frame_pulse_in = !(slot_pos == 9'h1fd || slot_pos == 9'h1fe);
   end
endmodule // tss_line_partner

// ===== testbench/tss_switch_bench.sv
// bench for the time slot switch
// partner drives the serial side
`timescale 1ns/1ps
`define CHK(got, exp) begin compares = compares + 1; if ((got) !== (exp)) begin errors = errors + 1; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tss_switch_bench;
   reg        clock, rst, chip_select_n, data_strobe, read_not_write, master_output_enable, mo;
   reg  [5:0] addr_lines;
   reg  [7:0] tb_bus, q, e;
   reg  [7:0] hi [0:255];
   reg  [7:0] lo [0:255];
   wire       serial_clock_in, frame_pulse_in, control_channel_out, host_data_bus_en;
   wire       transfer_ack_n_drv, transfer_ack_n_en, ack_n;
   wire [7:0] serial_in_lines, serial_out_lines, serial_out_en, host_data_bus_drv, host_data_bus_pin;
   wire [8:0] slot_pos;
   wire [3:0] frame_no;
   integer    errors, compares, seed, i, k, x;
   // pulled-up ack; resolved bus
   assign ack_n = transfer_ack_n_en ? transfer_ack_n_drv : 1'b1;
   assign host_data_bus_pin = host_data_bus_en ? host_data_bus_drv : tb_bus;
   tss_switch DUT (.clock(clock), .rst(rst), .serial_in_lines(serial_in_lines), .frame_pulse_in(frame_pulse_in),
      .serial_clock_in(serial_clock_in), .master_output_enable(master_output_enable),
      .serial_out_lines(serial_out_lines), .serial_out_en(serial_out_en), .control_channel_out(control_channel_out),
      .chip_select_n(chip_select_n), .data_strobe(data_strobe), .read_not_write(read_not_write),
      .addr_lines(addr_lines), .host_data_bus_pin(host_data_bus_pin), .host_data_bus_drv(host_data_bus_drv),
      .host_data_bus_en(host_data_bus_en), .transfer_ack_n_drv(transfer_ack_n_drv),
      .transfer_ack_n_en(transfer_ack_n_en));
   tss_line_partner u_partner (.serial_clock_in(serial_clock_in), .frame_pulse_in(frame_pulse_in),
      .serial_in_lines(serial_in_lines), .slot_pos(slot_pos), .frame_no(frame_no));
   ////////////////////////////////////////
   function [7:0] in_byte(input [7:0] src);
      in_byte = {src[4:0], src[7:5]} ^ 8'h5a;
   endfunction
   // host byte or named source
   function [7:0] exp_byte(input integer n);
      exp_byte = hi[n][3] ? lo[n] : in_byte(lo[n]);
   endfunction
   // hold until ack, then release
   task host(input rnw, input [5:0] a, input [7:0] d, output [7:0] rd);
      integer n;
      begin
         @(negedge clock);
         read_not_write = rnw;
         addr_lines = a;
         tb_bus = rnw ? ~d : d;
         chip_select_n = 1'b0;
         data_strobe = 1'b1;
         n = 0;
         while (ack_n !== 1'b0 && n < 40) begin
            @(negedge clock);
            n = n + 1;
         end
         rd = host_data_bus_pin;
         `CHK(ack_n, 1'b0)
         data_strobe = 1'b0;
         chip_select_n = 1'b1;
         while (ack_n !== 1'b1 && n < 80) begin
            @(negedge clock);
            n = n + 1;
         end
         `CHK(ack_n, 1'b1)
      end
   endtask
   task sel(input [1:0] m, input [2:0] l);
      host(1'b0, 6'h00, {3'h0, m, l}, q);
   endtask
   task end_of_test;
      begin
         $display("compares %0d errors %0d", compares, errors);
         if (errors == 0 && compares > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   ////////////////////////////////////////
   // 250 MHz system clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // watchdog at 400 us, just past three frames
   initial begin
      repeat (100000) @(posedge clock);
      errors = errors + 1;
      end_of_test;
   end
   // main sequence
   initial begin
      seed = 32'h5b4e;
      errors = 0;
      compares = 0;
      {rst, chip_select_n, data_strobe, read_not_write, master_output_enable, mo} = 6'h33;
      addr_lines = 6'h00;
      tb_bus = 8'h00;
      repeat (6) @(negedge clock);
      rst = 1'b0;
      `CHK(serial_out_en, 8'h00)
      // strobe without select must not start an access
      data_strobe = 1'b1;
      repeat (20) @(negedge clock);
      `CHK(ack_n, 1'b1)
      data_strobe = 1'b0;
      for (i = 0; i < 256; i = i + 1) begin
         hi[i] = 8'($random(seed)) & 8'h0f;
         lo[i] = 8'($random(seed));
      end
      // corners: processor, broadcast, constant
      {hi[0], hi[1], hi[2], hi[255]} = 32'h0b010105;
      {lo[1], lo[2], lo[255]} = 24'h1f1f00;
      // high half first: outputs arm set up
      for (k = 2; k > 0; k = k - 1) begin
         for (i = 0; i < 256; i = i + 1) begin
            if (i[4:0] == 5'h00) sel(k[1:0], i[7:5]);
            host(1'b0, {1'b1, i[4:0]}, (k == 2) ? hi[i] : lo[i], q);
         end
      end
      host(1'b1, 6'h25, 8'h00, q);
      `CHK(q, lo[229])
      host(1'b1, 6'h00, 8'h00, q);
      `CHK(q, 8'h4f)
      // frame 3 is fresh; check every bit
      wait (frame_no == 4'h3);
      for (k = 0; k < 512; k = k + 1) begin
         @(posedge serial_clock_in);
         if (!slot_pos[0]) begin
            for (i = 0; i < 8; i = i + 1) begin
               x = i * 32 + slot_pos[8:4];
               e = exp_byte(x);
               `CHK(serial_out_en[i], hi[x][0] & mo)
               if (hi[x][0] & mo) `CHK(serial_out_lines[i], e[7 - slot_pos[3:1]])
            end
            `CHK(control_channel_out, hi[slot_pos[8:1]][1])
            if (slot_pos[8:1] == 8'd191) begin
               @(negedge clock);
               master_output_enable = 1'b0;
               mo = 1'b0;
            end
         end
      end
      @(negedge clock);
      master_output_enable = 1'b1;
      // data memory read-only
      sel(2'h0, 3'h3);
      host(1'b1, 6'h29, 8'h00, q);
      `CHK(q, in_byte(8'h69))
      host(1'b0, 6'h29, 8'h00, q);
      host(1'b1, 6'h29, 8'h00, q);
      `CHK(q, in_byte(8'h69))
      end_of_test;
   end
endmodule // tss_switch_bench
